// ==== design/tfc_checker.sv ====
// Packet formation, routing-direction, class-map and unsupported-request checker.
// Assumes one header strobe per packet with the link layer's measured lengths beside it.
//
// Overview of operation
// - Port checks end-to-end CRC when any function has that checking enabled.
// - With port checking on, every packet with digest bit set is CRC-checked.
// - CRC errors are logged only by functions that enable checking themselves.
// - Vendor type 0 message aimed at the bridge is an unsupported request.
// - Vendor type 1 message aimed at the bridge is dropped without error.
// - Message to the bridge with an unknown code is an unsupported request.
// - Poisoned IO, memory write or non-vendor data message to bridge is unsupported.
// - Downstream traffic through a downstream port with link down is unsupported.
// - Every received packet runs formation checks; format and type must be legal.
// - Payload above the configured maximum payload size is malformed.
// - For data packets the length field must match received payload.
// - With digest, total length must equal header, payload and CRC.
// - IO requests need length one, class zero, attributes zero, last enables zero.
// - Config requests need length one, class zero, attributes zero, last enables zero.
// - Interrupt, power, error, unlock, power-limit messages need class zero.
// - Route-to-root packets are malformed when received on an upstream port.
// - Broadcast packets are malformed when received on a downstream port.
// - Gathered packets only downstream, and only as turn-off acknowledge messages.
// - Ingress class must map to channel 0 through the ingress map.
// - Egress class must map to channel 0 through the egress map.
// - Malformed packet raises uncorrectable error, logs header, counts in mal_cnt.
// - Non-posted unsupported request gets completion from claimer or function 0.
`timescale 1ns/100ps
`include "tfc_defines.svh"

module tfc_checker #(
  parameter int NUM_FUNC = 1,
  parameter int FUNC_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_up,
  input wire logic rx_valid,
  input wire tfc_pkg::tfc_fmt_t rx_fmt,
  input wire tfc_pkg::tfc_type_t rx_type,
  input wire tfc_pkg::tfc_tc_t rx_tc,
  input wire logic [1:0] rx_attr,
  input wire logic rx_td,
  input wire logic rx_ep,
  input wire logic [9:0] rx_length,
  input wire logic [3:0] rx_last_be,
  input wire logic [7:0] rx_msg_code,
  input wire logic rx_to_bridge,
  input wire logic rx_downstream_flow,
  input wire tfc_pkg::tfc_dw_t rx_payload_dw,
  input wire logic [11:0] rx_total_dw,
  input wire logic rx_ecrc_bad,
  input wire logic rx_claimed,
  input wire logic [FUNC_W-1:0] rx_claim_func,
  input wire logic tx_valid,
  input wire tfc_pkg::tfc_tc_t tx_tc,
  output logic rx_malformed,
  output logic rx_ur,
  output logic rx_discard,
  output logic rx_ecrc_check,
  output logic [NUM_FUNC-1:0] rx_ecrc_log,
  output logic cpl_ur_req,
  output logic [FUNC_W-1:0] cpl_ur_func,
  output logic tx_malformed
);

  if (NUM_FUNC < 1 || NUM_FUNC > 8 || (1 << FUNC_W) < NUM_FUNC) begin : g_bad_param
    $error("tfc_checker: NUM_FUNC must be 1..8 and fit FUNC_W");
  end

  // Registers
  logic port_downstream;
  logic [2:0] max_payload_size_field;
  logic [NUM_FUNC-1:0] ecrc_en;
  tfc_pkg::tfc_map_t rx_map;
  tfc_pkg::tfc_map_t tx_map;
  logic [`TFC_ST_WIDTH-1:0] status;
  logic [31:0] hdr_log0;
  logic [31:0] hdr_log1;
  logic [15:0] mal_cnt;

  // APB decode
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pwrite;
  wire hit_ctrl = paddr == `TFC_OFF_CTRL;
  wire hit_ecrc = paddr == `TFC_OFF_ECRC_EN;
  wire hit_rxmap = paddr == `TFC_OFF_RX_MAP;
  wire hit_txmap = paddr == `TFC_OFF_TX_MAP;
  wire hit_status = paddr == `TFC_OFF_STATUS;
  wire hit_log0 = paddr == `TFC_OFF_HDR_LOG0;
  wire hit_log1 = paddr == `TFC_OFF_HDR_LOG1;
  wire hit_cnt = paddr == `TFC_OFF_MAL_CNT;
  wire hit_any = hit_ctrl | hit_ecrc | hit_rxmap | hit_txmap | hit_status | hit_log0 |
                 hit_log1 | hit_cnt;
  wire [31:0] ctrl_word = {25'h0000000, max_payload_size_field, 3'h0, port_downstream};
  wire [31:0] rd_word =
    hit_ctrl ? ctrl_word :
    hit_ecrc ? 32'(ecrc_en) :
    hit_rxmap ? {24'h000000, rx_map} :
    hit_txmap ? {24'h000000, tx_map} :
    hit_status ? {28'h0000000, status} :
    hit_log0 ? hdr_log0 :
    hit_log1 ? hdr_log1 :
    hit_cnt ? {16'h0000, mal_cnt} : 32'h0000_0000;

  // Zero-wait access phase; read data and error are settled in the setup cycle
  assign pready = psel & penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pce && setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= ~hit_any;
    end
  end

  // Decode of the received header
  wire is_msg = rx_type[4:3] == `TFC_TYPE_MSG_HI;
  wire [2:0] route = rx_type[2:0];
  wire has_data = rx_fmt[1];
  wire is_mem = rx_type == `TFC_TYPE_MEM || rx_type == `TFC_TYPE_MEM_LK;
  wire is_io = rx_type == `TFC_TYPE_IO;
  wire is_cfg = rx_type == `TFC_TYPE_CFG0 || rx_type == `TFC_TYPE_CFG1;
  wire is_cpl = rx_type == `TFC_TYPE_CPL || rx_type == `TFC_TYPE_CPL_LK;
  wire msg_int = rx_msg_code[7:3] == `TFC_MSG_INT_HI;
  wire msg_pm = rx_msg_code == `TFC_MSG_PM_NAK || rx_msg_code == `TFC_MSG_PM_PME ||
                rx_msg_code == `TFC_MSG_PM_OFF || rx_msg_code == `TFC_MSG_PM_TO_ACK;
  wire msg_err = rx_msg_code == `TFC_MSG_ERR_COR || rx_msg_code == `TFC_MSG_ERR_NF ||
                 rx_msg_code == `TFC_MSG_ERR_F;
  wire msg_misc = rx_msg_code == `TFC_MSG_UNLOCK || rx_msg_code == `TFC_MSG_SET_PWR;
  wire msg_vend0 = rx_msg_code == `TFC_MSG_VEND0;
  wire msg_vend1 = rx_msg_code == `TFC_MSG_VEND1;
  wire msg_known = msg_int | msg_pm | msg_err | msg_misc | msg_vend0 | msg_vend1;

  // Legal format and type pairs; messages need a defined routing code
  wire fmt_ok =
    (is_mem) ? (rx_type == `TFC_TYPE_MEM || !has_data) :
    (is_io | is_cfg) ? !rx_fmt[0] :
    (is_cpl) ? !rx_fmt[0] :
    (is_msg) ? (rx_fmt[0] && route != 3'h6 && route != 3'h7) : 1'b0;

  // Lengths in doublewords; a zero length field means the largest size
  wire tfc_pkg::tfc_dw_t len_dw = (rx_length == 10'h000) ? `TFC_LEN_ZERO_DW :
                                  {1'b0, rx_length};
  wire [2:0] mps_eff = (max_payload_size_field > `TFC_MPS_MAX) ? `TFC_MPS_MAX : max_payload_size_field;
  wire tfc_pkg::tfc_dw_t mps_dw = `TFC_MPS_BASE_DW << mps_eff;
  wire [11:0] hdr_dw = rx_fmt[0] ? 12'h004 : 12'h003;
  wire [11:0] pay_dw = has_data ? {1'b0, len_dw} : 12'h000;
  wire [11:0] exp_dw = hdr_dw + pay_dw + 12'h001;

  wire port_ecrc = |ecrc_en;

  // Formation failures, one term each
  wire bad_fmt = !fmt_ok;
  wire bad_mps = has_data && len_dw > mps_dw;
  wire bad_len = has_data && len_dw != rx_payload_dw;
  wire bad_td = rx_td && rx_total_dw != exp_dw;
  wire one_dw_ok = rx_length == 10'h001 && rx_tc == 3'h0 && rx_attr == 2'h0 &&
                   rx_last_be == 4'h0;
  wire bad_io = is_io && !one_dw_ok;
  wire bad_cfg = is_cfg && !one_dw_ok;
  wire bad_mtc = is_msg && (msg_int | msg_pm | msg_err | msg_misc) && rx_tc != 3'h0;
  wire bad_rtrc = is_msg && route == `TFC_RT_TO_RC && !port_downstream;
  wire bad_bcast = is_msg && route == `TFC_RT_BCAST && port_downstream;
  wire bad_gath = is_msg && route == `TFC_RT_GATHER &&
                  (!port_downstream || rx_msg_code != `TFC_MSG_PM_TO_ACK);
  wire bad_intx = is_msg && msg_int && !port_downstream;
  wire bad_rxmap = !rx_map[rx_tc];

  // One indication however many checks fail
  wire mal = bad_fmt | bad_mps | bad_len | bad_td | bad_io | bad_cfg | bad_mtc |
             bad_rtrc | bad_bcast | bad_gath | bad_intx | bad_rxmap;

  // Unsupported-request causes; malformed outranks them
  wire ur_vend0 = is_msg && msg_vend0 && rx_to_bridge;
  wire ur_code = is_msg && !msg_known && rx_to_bridge;
  wire poison_kind = is_io || (is_mem && has_data) || (is_msg && has_data && !msg_vend0 &&
                     !msg_vend1);
  wire ur_poison = rx_ep && rx_to_bridge && poison_kind;
  wire ur_link = port_downstream && !link_up && rx_downstream_flow;
  wire ur = !mal && (ur_vend0 | ur_code | ur_poison | ur_link);
  wire drop_vend1 = !mal && !ur && is_msg && msg_vend1 && rx_to_bridge;
  wire non_posted = (is_mem && !has_data) || is_io || is_cfg;

  wire rx_go = pce && rx_valid;
  wire tx_bad = tx_valid && !tx_map[tx_tc];

  // Event outputs: one-cycle pulses after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_malformed <= 1'b0;
      rx_ur <= 1'b0;
      rx_discard <= 1'b0;
      rx_ecrc_check <= 1'b0;
      rx_ecrc_log <= '0;
      cpl_ur_req <= 1'b0;
      cpl_ur_func <= '0;
      tx_malformed <= 1'b0;
    end else if (pce) begin
      rx_malformed <= rx_valid && mal;
      rx_ur <= rx_valid && ur;
      rx_discard <= rx_valid && drop_vend1;
      rx_ecrc_check <= rx_valid && rx_td && port_ecrc;
      rx_ecrc_log <= (rx_valid && rx_td && rx_ecrc_bad) ? ecrc_en : '0;
      cpl_ur_req <= rx_valid && ur && non_posted;
      cpl_ur_func <= rx_claimed ? rx_claim_func : '0;
      tx_malformed <= tx_bad;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_downstream <= 1'(`TFC_CTRL_RST);
      max_payload_size_field <= 3'h0;
      ecrc_en <= NUM_FUNC'(`TFC_ECRC_RST);
      rx_map <= `TFC_MAP_RST;
      tx_map <= `TFC_MAP_RST;
    end else if (pce && wr_go) begin
      if (hit_ctrl) begin
        port_downstream <= pwdata[`TFC_CTRL_DOWNSTREAM_BIT];
        max_payload_size_field <= pwdata[`TFC_CTRL_MPS_LSB +: 3];
      end
      if (hit_ecrc) begin
        ecrc_en <= pwdata[NUM_FUNC-1:0];
      end
      // Class 0 always rides channel 0
      if (hit_rxmap) begin
        rx_map <= {pwdata[7:1], 1'b1};
      end
      if (hit_txmap) begin
        tx_map <= {pwdata[7:1], 1'b1};
      end
    end
  end

  // Sticky status, write one to clear; a new event in the clearing cycle wins
  wire [`TFC_ST_WIDTH-1:0] st_set = {rx_go && drop_vend1, pce && tx_bad, rx_go && ur,
                                     rx_go && mal};
  wire [`TFC_ST_WIDTH-1:0] st_clr = (wr_go && hit_status) ? pwdata[`TFC_ST_WIDTH-1:0] : '0;
  wire [`TFC_ST_WIDTH-1:0] next_status = (status & ~st_clr) | st_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (pce) begin
      status <= next_status;
    end
  end

  // Header log of the latest malformed packet, and a saturating count
  wire [31:0] next_log0 = {rx_fmt, rx_type, 1'b0, rx_tc, 2'h0, rx_attr, rx_td, rx_ep,
                           5'h00, rx_length};
  wire [31:0] next_log1 = {12'h000, rx_last_be, rx_msg_code, rx_payload_dw[7:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_log0 <= 32'h0000_0000;
      hdr_log1 <= 32'h0000_0000;
      mal_cnt <= 16'h0000;
    end else if (rx_go && mal) begin
      hdr_log0 <= next_log0;
      hdr_log1 <= next_log1;
      if (mal_cnt != 16'hFFFF) begin
        mal_cnt <= mal_cnt + 16'h0001;
      end
    end else if (pce && wr_go && hit_cnt) begin
      mal_cnt <= 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ecrc_port_gate: assert property (rx_go && rx_td && |ecrc_en |=> rx_ecrc_check)
    else $error("digest packet not checked while port CRC enabled");
  a_ecrc_port_off: assert property (rx_go && ecrc_en == '0 |=> !rx_ecrc_check)
    else $error("CRC check with no function enabled");
  a_ecrc_func_log: assert property (rx_ecrc_log != '0 |-> (rx_ecrc_log & ~$past(ecrc_en)) == '0)
    else $error("CRC error logged by a disabled function");
  a_mps_limit: assert property (rx_go && has_data && len_dw > mps_dw |=> rx_malformed)
    else $error("oversized payload not malformed");
  a_io_form: assert property (rx_go && is_io && rx_tc != 3'h0 |=> rx_malformed)
    else $error("IO request with class not zero accepted");
  a_cfg_form: assert property (rx_go && is_cfg && rx_length != 10'h001 |=> rx_malformed)
    else $error("config request with bad length accepted");
  a_route_up: assert property (rx_go && bad_rtrc |=> rx_malformed && !rx_ur)
    else $error("route-to-root on upstream port accepted");
  a_bcast_down: assert property (rx_go && is_msg && route == `TFC_RT_BCAST
    && port_downstream |=> rx_malformed)
    else $error("broadcast on downstream port accepted");
  a_rx_map: assert property (rx_go && !rx_map[rx_tc] |=> rx_malformed)
    else $error("unmapped ingress class accepted");
  a_tx_map: assert property (pce && tx_valid && !tx_map[tx_tc] |=> tx_malformed)
    else $error("unmapped egress class accepted");
  a_single_ind: assert property (rx_ur |-> !rx_malformed && !rx_discard)
    else $error("more than one indication for a packet");
  a_vend1_quiet: assert property (rx_discard |-> !rx_ur && !cpl_ur_req)
    else $error("vendor type 1 drop reported an error");
  a_link_down: assert property (rx_go && ur_link && !mal |=> rx_ur)
    else $error("traffic through dead downstream link not unsupported");
  a_cpl_fn0: assert property (rx_go && ur && non_posted && !rx_claimed
    |=> cpl_ur_req && cpl_ur_func == '0)
    else $error("unclaimed request completion not from function 0");
  a_mal_sticky: assert property (rx_go && mal |=> status[`TFC_ST_RX_MAL])
    else $error("malformed status not set");

  // Cause by cause; unsupported and discard yield to malformed
  a_vend0_ur: assert property (rx_go && ur_vend0 && !mal |=> rx_ur)
    else $error("vendor type 0 not unsupported");
  a_vend1_drop: assert property (rx_go && drop_vend1 |=> rx_discard)
    else $error("vendor type 1 not dropped");
  a_code_ur: assert property (rx_go && ur_code && !mal |=> rx_ur)
    else $error("unknown message code not unsupported");
  a_poison_ur: assert property (rx_go && ur_poison && !mal |=> rx_ur)
    else $error("poisoned request not unsupported");
  a_fmt_legal: assert property (rx_go && !fmt_ok |=> rx_malformed)
    else $error("illegal format and type accepted");
  a_len_match: assert property (rx_go && has_data && len_dw != rx_payload_dw
    |=> rx_malformed)
    else $error("length field mismatch accepted");
  a_digest_len: assert property (rx_go && rx_td && rx_total_dw != exp_dw
    |=> rx_malformed)
    else $error("digest packet length mismatch accepted");
  a_msg_class: assert property (rx_go && is_msg && msg_misc && rx_tc != 3'h0
    |=> rx_malformed)
    else $error("class-zero message with other class accepted");
  a_gather_ack: assert property (rx_go && is_msg && route == `TFC_RT_GATHER &&
    rx_msg_code != `TFC_MSG_PM_TO_ACK |=> rx_malformed)
    else $error("gathered packet other than acknowledge accepted");
  a_pulse_only: assert property (pce && !rx_valid
    |=> !rx_malformed && !rx_ur && !rx_discard && !cpl_ur_req)
    else $error("indication without a strobe");
  a_clean_quiet: assert property (rx_go && !mal && !ur && !drop_vend1
    |=> !rx_malformed && !rx_ur && !rx_discard)
    else $error("indication for a clean packet");
  a_tx_quiet: assert property (pce && !tx_bad |=> !tx_malformed)
    else $error("mapped egress class flagged");
  a_ecrc_no_td: assert property (rx_go && !rx_td
    |=> !rx_ecrc_check && rx_ecrc_log == '0)
    else $error("CRC activity without digest");
  a_cpl_claim: assert property (rx_go && ur && non_posted && rx_claimed
    |=> cpl_ur_req && cpl_ur_func == $past(rx_claim_func))
    else $error("completion not from claiming function");
  a_cnt_step: assert property (rx_go && mal && mal_cnt != 16'hFFFF
    |=> mal_cnt == $past(mal_cnt) + 16'h0001)
    else $error("malformed count did not step");
  a_cnt_hold: assert property (!(rx_go && mal) && !(pce && wr_go && hit_cnt)
    |=> $stable(mal_cnt))
    else $error("malformed count moved");
  a_log_capture: assert property (rx_go && mal
    |=> hdr_log0 == $past(next_log0) && hdr_log1 == $past(next_log1))
    else $error("header of malformed packet not logged");
  a_log_hold: assert property (!(rx_go && mal)
    |=> $stable(hdr_log0) && $stable(hdr_log1))
    else $error("header log moved");
  a_status_clear: assert property (pce && wr_go && hit_status && !(rx_go && mal) &&
    pwdata[`TFC_ST_RX_MAL] |=> !status[`TFC_ST_RX_MAL])
    else $error("malformed status not cleared");
  // Unmapped address and a frozen clock enable have no rule of their own
  a_bad_addr: assert property (pce && setup && !hit_any
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_freeze: assert property (!pce
    |=> $stable(status) && $stable(rx_malformed) && $stable(tx_malformed))
    else $error("state moved with clock enable low");

endmodule

// ==== shared/tfc_defines.svh ====
// Register map, field positions, reset values and packet codes of the formation checker.
// Included by the checker design; holds definitions only.
`ifndef TFC_DEFINES_SVH
`define TFC_DEFINES_SVH

`define TFC_OFF_CTRL 8'h00
`define TFC_OFF_ECRC_EN 8'h04
`define TFC_OFF_RX_MAP 8'h08
`define TFC_OFF_TX_MAP 8'h0C
`define TFC_OFF_STATUS 8'h10
`define TFC_OFF_HDR_LOG0 8'h14
`define TFC_OFF_HDR_LOG1 8'h18
`define TFC_OFF_MAL_CNT 8'h1C

`define TFC_CTRL_DOWNSTREAM_BIT 0
`define TFC_CTRL_MPS_LSB 4
`define TFC_CTRL_RST 32'h0000_0000
`define TFC_MAP_RST 8'h01
`define TFC_ECRC_RST 8'h00

`define TFC_ST_RX_MAL 0
`define TFC_ST_RX_UR 1
`define TFC_ST_TX_MAL 2
`define TFC_ST_DISCARD 3
`define TFC_ST_WIDTH 4

`define TFC_TYPE_MEM 5'h00
`define TFC_TYPE_MEM_LK 5'h01
`define TFC_TYPE_IO 5'h02
`define TFC_TYPE_CFG0 5'h04
`define TFC_TYPE_CFG1 5'h05
`define TFC_TYPE_CPL 5'h0A
`define TFC_TYPE_CPL_LK 5'h0B
`define TFC_TYPE_MSG_HI 2'h2

`define TFC_RT_TO_RC 3'h0
`define TFC_RT_BCAST 3'h3
`define TFC_RT_GATHER 3'h5

`define TFC_MSG_UNLOCK 8'h00
`define TFC_MSG_PM_NAK 8'h14
`define TFC_MSG_PM_PME 8'h18
`define TFC_MSG_PM_OFF 8'h19
`define TFC_MSG_PM_TO_ACK 8'h1B
`define TFC_MSG_INT_HI 5'h04
`define TFC_MSG_ERR_COR 8'h30
`define TFC_MSG_ERR_NF 8'h31
`define TFC_MSG_ERR_F 8'h33
`define TFC_MSG_SET_PWR 8'h50
`define TFC_MSG_VEND0 8'h7E
`define TFC_MSG_VEND1 8'h7F

`define TFC_MPS_BASE_DW 11'h020
`define TFC_MPS_MAX 3'h5
`define TFC_LEN_ZERO_DW 11'h400

`endif

// ==== shared/tfc_pkg.sv ====
// Types shared by the formation checker and its bench.
// Assumes the constants of tfc_defines.svh.
package tfc_pkg;
  typedef logic [1:0] tfc_fmt_t;
  typedef logic [4:0] tfc_type_t;
  typedef logic [2:0] tfc_tc_t;
  typedef logic [7:0] tfc_map_t;
  typedef logic [10:0] tfc_dw_t;
endpackage

// ==== test/tfc_link_partner.sv ====
// Link-side packet source: presents one header strobe per send call.
// Assumes calls start just after a rising pclk edge; fields are junk outside strobes.
`timescale 1ns/100ps
module tfc_link_partner (
  input wire logic pclk,
  output logic rx_valid,
  output tfc_pkg::tfc_fmt_t rx_fmt,
  output tfc_pkg::tfc_type_t rx_type,
  output tfc_pkg::tfc_tc_t rx_tc,
  output logic [1:0] rx_attr,
  output logic rx_td,
  output logic rx_ep,
  output logic [9:0] rx_length,
  output logic [3:0] rx_last_be,
  output logic [7:0] rx_msg_code,
  output logic rx_to_bridge,
  output logic rx_downstream_flow,
  output logic rx_ecrc_bad,
  output logic rx_claimed,
  output tfc_pkg::tfc_dw_t rx_payload_dw,
  output logic [11:0] rx_total_dw,
  output logic [2:0] rx_claim_func
);
  logic [65:0] hdr;
  assign {rx_fmt, rx_type, rx_tc, rx_attr, rx_td, rx_ep, rx_length, rx_last_be, rx_msg_code,
    rx_to_bridge, rx_downstream_flow, rx_ecrc_bad, rx_claimed, rx_payload_dw, rx_total_dw,
    rx_claim_func} = hdr;
  initial begin
    rx_valid = 1'b0;
    hdr = '0;
  end
  // Flags: bridge, downstream flow, bad CRC, claimed, last enables, length fault, total fault
  task automatic send(input logic [1:0] f, input logic [4:0] t, input logic [2:0] c,
    input logic [1:0] a, input logic d, input logic e, input logic [9:0] l,
    input logic [7:0] m, input logic [6:0] fl);
    logic [10:0] pay;
    logic [11:0] tot;
    pay = f[1] ? ((l == 10'h000) ? 11'h400 : {1'b0, l}) : 11'h000;
    tot = {1'b0, pay} + (f[0] ? 12'h004 : 12'h003) + {11'h000, d};
    pay = pay + {10'h000, fl[1]};
    tot = tot + {11'h000, fl[0]};
    @(posedge pclk);
    rx_valid <= 1'b1;
    hdr <= {f, t, c, a, d, e, l, fl[2] ? 4'h1 : 4'h0, m, fl[6:3], pay, tot, 3'h1};
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Inverted junk so a stale header can never pass for a fresh one
    hdr <= ~hdr;
  endtask
endmodule

// ==== test/tfc_checker_tb_top.sv ====
// Self-checking bench for the formation checker: APB register tasks plus packet sequences.
// Assumes the link partner model drives the receive header fields.
`timescale 1ns/100ps
module tfc_checker_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, link_up = 1'b1, tx_valid = 1'b0;
  tfc_pkg::tfc_tc_t tx_tc = 3'h0;
  logic rx_valid, rx_td, rx_ep, rx_to_bridge, rx_downstream_flow, rx_ecrc_bad, rx_claimed;
  tfc_pkg::tfc_fmt_t rx_fmt;
  tfc_pkg::tfc_type_t rx_type;
  tfc_pkg::tfc_tc_t rx_tc;
  logic [1:0] rx_attr, rx_ecrc_log;
  logic [9:0] rx_length;
  logic [3:0] rx_last_be;
  logic [7:0] rx_msg_code;
  tfc_pkg::tfc_dw_t rx_payload_dw;
  logic [11:0] rx_total_dw;
  logic [2:0] rx_claim_func, cpl_ur_func;
  logic rx_malformed, rx_ur, rx_discard, rx_ecrc_check, cpl_ur_req, tx_malformed;
  logic [31:0] rd;
  logic last_err;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_mal = 0;
  wire logic [9:0] rx_obs = {cpl_ur_req ? cpl_ur_func : 3'h0, cpl_ur_req, rx_ecrc_check,
    rx_ecrc_log, rx_malformed, rx_ur, rx_discard};

  always #50 pclk = ~pclk;

  tfc_checker #(.NUM_FUNC(2), .FUNC_W(3)) dut_u (.pclk, .presetn, .pce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up, .rx_valid, .rx_fmt,
    .rx_type, .rx_tc, .rx_attr, .rx_td, .rx_ep, .rx_length, .rx_last_be, .rx_msg_code,
    .rx_to_bridge, .rx_downstream_flow, .rx_payload_dw, .rx_total_dw, .rx_ecrc_bad,
    .rx_claimed, .rx_claim_func, .tx_valid, .tx_tc, .rx_malformed, .rx_ur, .rx_discard,
    .rx_ecrc_check, .rx_ecrc_log, .cpl_ur_req, .cpl_ur_func, .tx_malformed);

  tfc_link_partner partner_u (.pclk, .rx_valid, .rx_fmt, .rx_type, .rx_tc, .rx_attr, .rx_td,
    .rx_ep, .rx_length, .rx_last_be, .rx_msg_code, .rx_to_bridge, .rx_downstream_flow,
    .rx_ecrc_bad, .rx_claimed, .rx_payload_dw, .rx_total_dw, .rx_claim_func);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Expected word: func[9:7], cpl req, crc check, crc log[4:3], malformed, ur, discard
  task automatic pkt(input logic [1:0] f, input logic [4:0] t, input logic [2:0] c,
    input logic [1:0] a, input logic d, input logic e, input logic [9:0] l,
    input logic [7:0] m, input logic [6:0] fl, input logic [9:0] ex);
    if (pce) n_mal += ex[2];
    partner_u.send(f, t, c, a, d, e, l, m, fl);
    #1;
    check(rx_obs, ex);
    @(posedge pclk);
    #1;
    check(rx_obs, 10'h000);
  endtask

  task automatic txc(input logic [2:0] t, input logic ex);
    @(posedge pclk);
    tx_valid <= 1'b1;
    tx_tc <= t;
    @(posedge pclk);
    tx_valid <= 1'b0;
    #1;
    check(tx_malformed, ex);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0001);
    rdc(8'h0C, 32'h0000_0001);
    rdc(8'h10, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h00, 10'h000);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h021, 8'h00, 7'h00, 10'h004);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h02, 10'h004);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b1, 1'b0, 10'h004, 8'h00, 7'h01, 10'h004);
    pkt(2'h0, 5'h1F, 3'h0, 2'h0, 1'b0, 1'b0, 10'h001, 8'h00, 7'h00, 10'h004);
    pkt(2'h2, 5'h02, 3'h0, 2'h0, 1'b0, 1'b0, 10'h001, 8'h00, 7'h00, 10'h000);
    pkt(2'h2, 5'h02, 3'h0, 2'h1, 1'b0, 1'b0, 10'h001, 8'h00, 7'h00, 10'h004);
    pkt(2'h0, 5'h02, 3'h0, 2'h0, 1'b0, 1'b0, 10'h001, 8'h00, 7'h04, 10'h004);
    pkt(2'h0, 5'h04, 3'h0, 2'h0, 1'b0, 1'b0, 10'h001, 8'h00, 7'h00, 10'h000);
    pkt(2'h2, 5'h05, 3'h0, 2'h0, 1'b0, 1'b0, 10'h002, 8'h00, 7'h00, 10'h004);
    pkt(2'h2, 5'h02, 3'h1, 2'h1, 1'b0, 1'b0, 10'h002, 8'h00, 7'h04, 10'h004);
    pkt(2'h2, 5'h00, 3'h2, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h00, 10'h004);
    apb(1'b1, 8'h08, 32'h0000_00FF);
    pkt(2'h2, 5'h00, 3'h2, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h00, 10'h000);
    pkt(2'h1, 5'h13, 3'h1, 2'h0, 1'b0, 1'b0, 10'h000, 8'h00, 7'h00, 10'h004);
    pkt(2'h1, 5'h13, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h00, 7'h00, 10'h000);
    pkt(2'h1, 5'h10, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h30, 7'h00, 10'h004);
    apb(1'b1, 8'h00, 32'h0000_0001);
    pkt(2'h1, 5'h10, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h30, 7'h00, 10'h000);
    pkt(2'h1, 5'h13, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h00, 7'h00, 10'h004);
    pkt(2'h1, 5'h15, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h1B, 7'h00, 10'h000);
    pkt(2'h1, 5'h15, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h30, 7'h00, 10'h004);
    pkt(2'h1, 5'h14, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h7E, 7'h40, 10'h002);
    pkt(2'h1, 5'h14, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h7F, 7'h40, 10'h001);
    pkt(2'h3, 5'h14, 3'h0, 2'h0, 1'b0, 1'b1, 10'h001, 8'h7F, 7'h40, 10'h001);
    pkt(2'h1, 5'h14, 3'h0, 2'h0, 1'b0, 1'b0, 10'h000, 8'h99, 7'h40, 10'h002);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b0, 1'b1, 10'h004, 8'h00, 7'h40, 10'h002);
    @(posedge pclk);
    link_up <= 1'b0;
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h20, 10'h002);
    pkt(2'h0, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h20, 10'h042);
    pkt(2'h0, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h28, 10'h0C2);
    @(posedge pclk);
    link_up <= 1'b1;
    pkt(2'h0, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h20, 10'h000);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b1, 1'b0, 10'h004, 8'h00, 7'h10, 10'h000);
    apb(1'b1, 8'h04, 32'h0000_0002);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b1, 1'b0, 10'h004, 8'h00, 7'h10, 10'h030);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b1, 1'b0, 10'h004, 8'h00, 7'h00, 10'h020);
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h004, 8'h00, 7'h10, 10'h000);
    txc(3'h3, 1'b1);
    txc(3'h0, 1'b0);
    apb(1'b1, 8'h0C, 32'h0000_0009);
    txc(3'h3, 1'b0);
    @(posedge pclk);
    pce <= 1'b0;
    pkt(2'h2, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 10'h021, 8'h00, 7'h00, 10'h000);
    @(posedge pclk);
    pce <= 1'b1;
    rdc(8'h10, 32'h0000_000F);
    rdc(8'h1C, n_mal);
    rdc(8'h14, 32'h6A00_0000);
    rdc(8'h18, 32'h0000_3000);
    rdc(8'h20, 32'h0000_0000);
    check(last_err, 1'b1);
    apb(1'b1, 8'h10, 32'h0000_000F);
    rdc(8'h10, 32'h0000_0000);
    give_verdict();
  end

  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule
